// File: hdl/wfs_regs.vh
// register map, field layout and timing constants of the slot sequencer
`ifndef WFS_REGS_VH
`define WFS_REGS_VH

// ----------------------------------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------------------------------
`define WFS_IDX_W 6
`define WFS_IDX_CTRL 6'h0c
`define WFS_IDX_SLOT_FIRST 6'h0f
`define WFS_IDX_SLOT_SEVEN 6'h15
`define WFS_IDX_SLOT_EIGHT 6'h16
`define WFS_IDX_LOOP_LO 6'h17
`define WFS_IDX_LOOP_HI 6'h18
`define WFS_IDX_STATUS 6'h19

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define WFS_ADDR_W 8
`define WFS_ADDR_IDX_LSB 2
`define WFS_ADDR_IDX_MSB 7
`define WFS_DATA_W 32
`define WFS_BE_W 4
`define WFS_BE_LOW 0

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define WFS_CTRL_START_BIT 0
`define WFS_SLOT_DELAY_BIT 7
`define WFS_ENTRY_MSB 6
`define WFS_ENTRY_W 7
`define WFS_STAT_BUSY_BIT 0
`define WFS_STAT_DELAY_BIT 1
`define WFS_STAT_PLAY_BIT 2
`define WFS_STAT_SLOT_LSB 4
`define WFS_STAT_SLOT_MSB 6
`define WFS_REPEAT_W 2

// ----------------------------------------------------------------
// reset values and slot counts
// ----------------------------------------------------------------
`define WFS_RST_BYTE 8'h00
`define WFS_RST_WORD 32'h00000000
`define WFS_SLOT_NUM 8
`define WFS_SLOT_W 3
`define WFS_SLOT_ZERO 3'h0
`define WFS_SLOT_LAST 3'h7
`define WFS_ENTRY_STOP 8'h00
`define WFS_UNITS_ZERO 7'h00

// ----------------------------------------------------------------
// timing: delay unit in ms, clock in kHz, unit count in cycles
// ----------------------------------------------------------------
`define WFS_DELAY_UNIT_MS 10
`define WFS_CLK_KHZ 200000
// 10 ms at 200 MHz, sized to the unit counter so nothing is cut
`define WFS_UNIT_CYCLES 21'h1e8480
`define WFS_UNIT_CNT_W 21
`define WFS_UNIT_CNT_ZERO 21'h000000
`define WFS_UNIT_CNT_ONE 21'h000001

`endif

// File: hdl/wfs_slot_mem.v
// eight-entry slot store with one write port and two registered read ports
`timescale 1ns/1ps
`include "wfs_regs.vh"

module wfs_slot_mem (
	// clock and reset
	input wire clk_sys,
	input wire srst,
	// write port
	input wire wr_en,
	input wire [2:0] wr_addr,
	input wire [7:0] wr_data,
	// read port a (bus)
	input wire [2:0] rd_a_addr,
	output reg [7:0] rd_a_data,
	// read port b (sequencer)
	input wire [2:0] rd_b_addr,
	output reg [7:0] rd_b_data
);

	wire [7:0] slot_word [0:7];

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_slot
			reg [7:0] word;
			always @(posedge clk_sys) begin
				if (srst) begin
					word <= `WFS_RST_BYTE;
				end else if (wr_en && wr_addr == g) begin
					word <= wr_data;
				end
			end
			assign slot_word[g] = word;
		end
	endgenerate

	// ----------------------------------------------------------------
	// registered reads
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (srst) begin
			rd_a_data <= `WFS_RST_BYTE;
			rd_b_data <= `WFS_RST_BYTE;
		end else begin
			rd_a_data <= slot_word[rd_a_addr];
			rd_b_data <= slot_word[rd_b_addr];
		end
	end

endmodule

// File: hdl/wfs_sequencer.v
// waveform slot sequencer with avalon-mm register slave
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "wfs_regs.vh"

module wfs_sequencer #(
	parameter [20:0] DELAY_UNIT_CYCLES = `WFS_UNIT_CYCLES
) (
	// clock and reset
	input wire clk_sys,
	input wire srst,
	// avalon-mm slave
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// drive engine handshake
	output wire wave_play,
	output reg [6:0] wave_id,
	input wire wave_done,
	// sequencer state
	output wire seq_busy,
	output wire seq_delay_active
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_FETCH = 3'h1;
	localparam [2:0] ST_LOAD = 3'h2;
	localparam [2:0] ST_LOOK = 3'h3;
	localparam [2:0] ST_PLAY = 3'h4;
	localparam [2:0] ST_DELAY = 3'h5;
	localparam [2:0] ST_DONE = 3'h6;

	localparam [1:0] RD_IDLE = 2'h0;
	localparam [1:0] RD_MEM = 2'h1;
	localparam [1:0] RD_ANS = 2'h2;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function is_slot;
		input [5:0] idx;
		begin
			is_slot = (idx >= `WFS_IDX_SLOT_FIRST) &&
				(idx <= `WFS_IDX_SLOT_EIGHT);
		end
	endfunction

	function [2:0] slot_of;
		input [5:0] idx;
		reg [5:0] diff;
		begin
			diff = idx - `WFS_IDX_SLOT_FIRST;
			slot_of = diff[2:0];
		end
	endfunction

	function [1:0] repeat_of;
		input [15:0] all;
		input [2:0] slot;
		begin
			repeat_of = all[{slot, 1'b0} +: 2];
		end
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	wire [5:0] bus_idx;
	wire wr_low;
	wire slot_wr;
	wire ctrl_wr;
	wire start_req;
	wire stop_req;
	wire [7:0] mem_a_data;
	wire [7:0] mem_b_data;
	wire [15:0] repeat_all;
	wire entry_is_delay;
	wire [1:0] slot_repeat_count;

	reg [1:0] rd_phase;
	reg [7:0] loop_lo;
	reg [7:0] loop_hi;
	reg [2:0] state;
	reg [2:0] slot_idx;
	reg [7:0] entry;
	reg [1:0] rep_cnt;
	reg [6:0] units_left;
	reg [20:0] unit_cnt;
	reg [7:0] status_byte;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign bus_idx = avs_address[`WFS_ADDR_IDX_MSB:`WFS_ADDR_IDX_LSB];
	assign wr_low = avs_write && avs_byteenable[`WFS_BE_LOW];
	assign slot_wr = wr_low && is_slot(bus_idx);
	assign ctrl_wr = wr_low && (bus_idx == `WFS_IDX_CTRL);
	assign start_req = ctrl_wr &&
		avs_writedata[`WFS_CTRL_START_BIT] && (state == ST_IDLE);
	// clearing the start bit while running cancels playback
	assign stop_req = ctrl_wr &&
		!avs_writedata[`WFS_CTRL_START_BIT];

	// writes finish in their first cycle; reads take two wait cycles
	assign avs_waitrequest = avs_read && (rd_phase != RD_ANS);

	// ----------------------------------------------------------------
	// slot storage
	// ----------------------------------------------------------------
	wfs_slot_mem u_slot_mem (
		.clk_sys(clk_sys),
		.srst(srst),
		.wr_en(slot_wr),
		.wr_addr(slot_of(bus_idx)),
		.wr_data(avs_writedata[7:0]),
		.rd_a_addr(slot_of(bus_idx)),
		.rd_a_data(mem_a_data),
		.rd_b_addr(slot_idx),
		.rd_b_data(mem_b_data)
	);

	// ----------------------------------------------------------------
	// repeat registers
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (srst) begin
			loop_lo <= `WFS_RST_BYTE;
			loop_hi <= `WFS_RST_BYTE;
		end else if (wr_low) begin
			if (bus_idx == `WFS_IDX_LOOP_LO) begin
				loop_lo <= avs_writedata[7:0];
			end
			if (bus_idx == `WFS_IDX_LOOP_HI) begin
				loop_hi <= avs_writedata[7:0];
			end
		end
	end

	assign repeat_all = {loop_hi, loop_lo};
	assign slot_repeat_count = repeat_of(repeat_all, slot_idx);

	// ----------------------------------------------------------------
	// status view
	// ----------------------------------------------------------------
	always @* begin
		status_byte = `WFS_RST_BYTE;
		status_byte[`WFS_STAT_BUSY_BIT] = seq_busy;
		status_byte[`WFS_STAT_DELAY_BIT] = seq_delay_active;
		status_byte[`WFS_STAT_PLAY_BIT] = wave_play;
		status_byte[`WFS_STAT_SLOT_MSB:`WFS_STAT_SLOT_LSB] = slot_idx;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// one extra cycle lets the slot store present its registered word
	always @(posedge clk_sys) begin
		if (srst) begin
			rd_phase <= RD_IDLE;
			avs_readdata <= `WFS_RST_WORD;
		end else begin
			case (rd_phase)
				RD_IDLE: begin
					if (avs_read) begin
						rd_phase <= RD_MEM;
					end
				end
				RD_MEM: begin
					rd_phase <= RD_ANS;
					avs_readdata <= `WFS_RST_WORD;
					if (is_slot(bus_idx)) begin
						avs_readdata[7:0] <= mem_a_data;
					end else begin
						case (bus_idx)
							`WFS_IDX_CTRL: begin
								avs_readdata[`WFS_CTRL_START_BIT] <= seq_busy;
							end
							`WFS_IDX_LOOP_LO: begin
								avs_readdata[7:0] <= loop_lo;
							end
							`WFS_IDX_LOOP_HI: begin
								avs_readdata[7:0] <= loop_hi;
							end
							`WFS_IDX_STATUS: begin
								avs_readdata[7:0] <= status_byte;
							end
							default: begin
								avs_readdata <= `WFS_RST_WORD;
							end
						endcase
					end
				end
				RD_ANS: begin
					rd_phase <= RD_IDLE;
				end
				default: begin
					rd_phase <= RD_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	assign entry_is_delay = entry[`WFS_SLOT_DELAY_BIT];

	always @(posedge clk_sys) begin
		if (srst) begin
			state <= ST_IDLE;
			slot_idx <= `WFS_SLOT_ZERO;
			entry <= `WFS_RST_BYTE;
			rep_cnt <= 2'h0;
			units_left <= `WFS_UNITS_ZERO;
			unit_cnt <= `WFS_UNIT_CNT_ZERO;
			wave_id <= `WFS_UNITS_ZERO;
		end else if (stop_req && state != ST_IDLE) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_req) begin
						slot_idx <= `WFS_SLOT_ZERO;
						rep_cnt <= 2'h0;
						state <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					// slot store latches slot_idx at this edge
					state <= ST_LOAD;
				end
				ST_LOAD: begin
					// entry snapshot guards replays against later writes
					entry <= mem_b_data;
					state <= ST_LOOK;
				end
				ST_LOOK: begin
					if (entry == `WFS_ENTRY_STOP) begin
						state <= ST_IDLE;
					end else if (entry_is_delay) begin
						units_left <= entry[`WFS_ENTRY_MSB:0];
						unit_cnt <= `WFS_UNIT_CNT_ZERO;
						state <= ST_DELAY;
					end else begin
						wave_id <= entry[`WFS_ENTRY_MSB:0];
						state <= ST_PLAY;
					end
				end
				ST_PLAY: begin
					if (wave_done) begin
						state <= ST_DONE;
					end
				end
				ST_DELAY: begin
					if (units_left == `WFS_UNITS_ZERO) begin
						state <= ST_DONE;
					end else if (unit_cnt ==
						DELAY_UNIT_CYCLES - `WFS_UNIT_CNT_ONE) begin
						unit_cnt <= `WFS_UNIT_CNT_ZERO;
						units_left <= units_left - 7'h01;
					end else begin
						unit_cnt <= unit_cnt + `WFS_UNIT_CNT_ONE;
					end
				end
				ST_DONE: begin
					if (rep_cnt != slot_repeat_count) begin
						rep_cnt <= rep_cnt + 2'h1;
						state <= ST_LOOK;
					end else if (slot_idx == `WFS_SLOT_LAST) begin
						state <= ST_IDLE;
					end else begin
						slot_idx <= slot_idx + 3'h1;
						rep_cnt <= 2'h0;
						state <= ST_FETCH;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// engine is only asked for a waveform, never during a wait
	assign wave_play = (state == ST_PLAY);
	assign seq_busy = (state != ST_IDLE);
	assign seq_delay_active = (state == ST_DELAY);

endmodule

// File: sim/wfs_sequencer_properties.sv
// checker of the slot sequencer ports
`timescale 1ns/1ps

module wfs_sequencer_props #(
	parameter [20:0] DELAY_UNIT_CYCLES = 21'h00000a
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// engine and state
	input wire logic wave_play,
	input wire logic [6:0] wave_id,
	input wire logic wave_done,
	input wire logic seq_busy,
	input wire logic seq_delay_active
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// ------------------------------------------------
	// sequences
	// ------------------------------------------------
	sequence s_rd_wait;
		avs_waitrequest[*2] ##1 !avs_waitrequest;
	endsequence
	sequence s_gap;
		!wave_play[*2];
	endsequence
	sequence s_start;
		seq_busy[*3] ##1 (wave_play || seq_delay_active || !seq_busy);
	endsequence
	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	rd_wait_a: assert property ($rose(avs_read) |-> s_rd_wait)
		else $error("read wait length wrong");
	wr_nowait_a: assert property (avs_write |-> !avs_waitrequest)
		else $error("write was stalled");
	rd_high_zero_a: assert property (
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	start_fetch_a: assert property (
		avs_write && avs_address == 8'h30 && avs_byteenable[0] &&
		avs_writedata[0] && !seq_busy |=> s_start)
		else $error("start did not reach first slot");
	play_hold_a: assert property (
		wave_play && !wave_done && !avs_write |=>
		wave_play && $stable(wave_id))
		else $error("play request dropped early");
	done_gap_a: assert property (wave_play && wave_done |=> s_gap)
		else $error("no idle gap after done");
	delay_idle_a: assert property (
		seq_delay_active |-> !wave_play && seq_busy)
		else $error("waveform driven in delay");
	idle_quiet_a: assert property (
		!seq_busy |-> !wave_play && !seq_delay_active)
		else $error("activity while idle");
endmodule

bind wfs_sequencer wfs_sequencer_props #(
	.DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES)
) u_wfs_sequencer_props (
	.clk_sys(clk_sys),
	.srst(srst),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.wave_play(wave_play),
	.wave_id(wave_id),
	.wave_done(wave_done),
	.seq_busy(seq_busy),
	.seq_delay_active(seq_delay_active)
);

// File: sim/wfs_sequencer_tb.sv
// self-checking bench of the slot sequencer
`timescale 1ns/1ps

module wfs_sequencer_tb;
	// short delay unit keeps the run brief
	localparam int UNIT = 10;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, wave_play, seq_busy, seq_delay_active;
	logic wave_done = 1'b0;
	logic [6:0] wave_id;
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;

	wfs_sequencer #(.DELAY_UNIT_CYCLES(21'h00000a)) u_wfs_sequencer (
		.clk_sys(clk_sys),
		.srst(srst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.wave_play(wave_play),
		.wave_id(wave_id),
		.wave_done(wave_done),
		.seq_busy(seq_busy),
		.seq_delay_active(seq_delay_active)
	);

	always #2.5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// ------------------------------------------------
	// bus and engine helpers
	// ------------------------------------------------
	// waitrequest is judged at the rising edge that takes the request
	task automatic bus(input logic wr, input logic [5:0] idx,
		input logic [7:0] d, input logic [3:0] be, output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, 4'h1, q);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, 4'h0, q);
		chk(q, e);
	endtask

	task automatic play(input logic [6:0] id);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (wave_play !== 1'b1 && n < 100);
		chk({24'h000000, wave_play, wave_id}, {24'h000000, 1'b1, id});
		repeat (3) @(posedge clk_sys);
		wave_done <= 1'b1;
		@(posedge clk_sys);
		wave_done <= 1'b0;
	endtask

	task automatic gap(input int units);
		int n;
		n = 0;
		while (seq_delay_active !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		n = 0;
		while (seq_delay_active === 1'b1 && n < 2000) begin
			@(negedge clk_sys);
			n++;
		end
		chk(n, units * UNIT + 1);
		@(posedge clk_sys);
	endtask

	// no further play and back to idle
	task automatic ends();
		logic p;
		p = 1'b0;
		repeat (8) begin
			@(negedge clk_sys);
			p = p | wave_play;
		end
		chk({30'h0, p, seq_busy}, 32'h00000000);
		@(posedge clk_sys);
	endtask

	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic t_regs();
		logic [31:0] q;
		rd(6'h15, 32'h00000000);
		rd(6'h16, 32'h00000000);
		wr(6'h15, 8'hd5);
		wr(6'h16, 8'h2a);
		bus(1'b1, 6'h15, 8'h00, 4'h0, q);
		wr(6'h3f, 8'hff);
		rd(6'h15, 32'h000000d5);
		rd(6'h16, 32'h0000002a);
		rd(6'h3f, 32'h00000000);
	endtask

	task automatic t_seq();
		int i;
		for (i = 0; i < 6; i++)
			wr(6'h0f + i[5:0], 8'h01 + i[7:0]);
		wr(6'h15, 8'h82);
		wr(6'h16, 8'h08);
		wr(6'h17, 8'h03);
		wr(6'h18, 8'h40);
		rd(6'h18, 32'h00000040);
		wr(6'h0c, 8'h01);
		for (i = 0; i < 4; i++)
			play(7'h01);
		for (i = 2; i < 7; i++)
			play(i[6:0]);
		gap(2);
		play(7'h08);
		play(7'h08);
		ends();
	endtask

	task automatic t_stop();
		wr(6'h17, 8'h00);
		wr(6'h18, 8'h00);
		wr(6'h0f, 8'h7f);
		wr(6'h10, 8'h00);
		wr(6'h0c, 8'h01);
		play(7'h7f);
		ends();
	endtask

	// busy and status seen during a wait, then a cancel
	task automatic t_cancel();
		wr(6'h0f, 8'h85);
		wr(6'h0c, 8'h01);
		rd(6'h0c, 32'h00000001);
		rd(6'h19, 32'h00000003);
		wr(6'h0c, 8'h00);
		rd(6'h0c, 32'h00000000);
	endtask

	// reset in mid-run clears slots and stops playback
	task automatic t_reset();
		wr(6'h15, 8'haa);
		wr(6'h0c, 8'h01);
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rd(6'h15, 32'h00000000);
		rd(6'h0c, 32'h00000000);
	endtask

	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_seq();
		t_stop();
		t_cancel();
		t_reset();
		print_verdict();
	end
endmodule
